// *** rtl/mct_pkg.sv ***
/*
 package for the six-channel timer configuration block: register
 offsets, field positions, reset values and code points.
 assumes a 32-bit ahb-lite bus with one word per register.
*/
package mct_pkg;
   localparam int          NUM_CH          = 6;
   // byte offsets, one 16-byte group per channel
   localparam logic [7:0]  CH_STRIDE       = 8'h10;
   localparam logic [3:0]  OFS_CLK_CTRL    = 4'h0;
   localparam logic [3:0]  OFS_MODE        = 4'h4;
   localparam logic [3:0]  OFS_IO_AB       = 4'h8;
   localparam logic [3:0]  OFS_IO_CD       = 4'hC;
   localparam logic [7:0]  OFS_RUN         = 8'h60;
   // reset values
   localparam logic [7:0]  MODE_RST        = 8'hC0;
   localparam logic [7:0]  IO_RST          = 8'h00;
   localparam logic [2:0]  CLK_SEL_RST     = 3'h0;
   localparam logic [1:0]  MODE_FIXED_ONES = 2'h3;
   // mode register fields
   localparam int          MODE_BUF_B_POS  = 5;
   localparam int          MODE_BUF_A_POS  = 4;
   localparam logic [3:0]  MD_NORMAL       = 4'h0;
   localparam logic [3:0]  MD_PWM1         = 4'h2;
   localparam logic [3:0]  MD_PWM2         = 4'h3;
   localparam logic [1:0]  MD_PHASE_TOP    = 2'h1;
   // prescaler taps: index into the divided-tick vector
   localparam int          PRE_W           = 12;
   localparam int          DIV1            = 0;
   localparam int          DIV4            = 1;
   localparam int          DIV16           = 2;
   localparam int          DIV64           = 3;
   localparam int          DIV256          = 4;
   localparam int          DIV1024         = 5;
   localparam int          DIV4096         = 6;
   // compare actions and capture edges
   localparam logic [1:0]  OC_NONE         = 2'h0;
   localparam logic [1:0]  OC_DRIVE0       = 2'h1;
   localparam logic [1:0]  OC_DRIVE1       = 2'h2;
   localparam logic [1:0]  OC_TOGGLE       = 2'h3;
   localparam logic [1:0]  CAP_NONE        = 2'h0;
   localparam logic [1:0]  CAP_RISE        = 2'h1;
   localparam logic [1:0]  CAP_FALL        = 2'h2;
   localparam logic [1:0]  CAP_BOTH        = 2'h3;
endpackage : mct_pkg

// *** rtl/mct_cfg.sv ***
/*
 clock source, mode and i/o function configuration for a six-channel
 16-bit timer, with its registers on an ahb-lite slave port.
 assumes all inputs synchronous to ref_clk except the external count
 pins and the two capture pins, which are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - codes 000..011 count on clock /1, /4, /16, /64; 000 at reset
// - channel 0 codes 100..111 count on external pins a, b, c, d
// - channel 1: 100 pin a, 101 pin b, 110 clock/256, 111 channel 2 wrap
// - channel 2: 100..110 pins a, b, c; 111 clock/1024
// - channel 3: 100 pin a; 101, 110, 111 clock /1024, /256, /4096
// - channel 4: 100 pin a, 101 pin c, 110 clock/1024, 111 channel 5 wrap
// - channel 5: 100 pin a, 101 pin c, 110 clock/256, 111 pin d
// - channels 1, 2, 4, 5 ignore clock select in phase counting
// - mode register resets to C0; top two bits read-only ones
// - channels 0, 3: bit 5 buffers b with d; d loses capture and compare
// - channels 0, 3: bit 4 buffers a with c; c loses capture and compare
// - other channels: mode bits 5, 4 read zero, writes ignored
// - mode field: normal, reserved, pwm1, pwm2, phase counting 1 to 4
// - i/o registers are 8 bits, reset 00; two on channels 0, 3
// - buffered c or d ignores its i/o setting
// - initial output level is loaded only while the counter is stopped, or at a counter clear in pwm mode 2
// - pwm mode 2: output selection is the level at counter clear
// - codes 0xxx: compare, off/drive 0/drive 1/toggle, initial level from bit 2
// - channel 0 b, d: capture rise, fall, both, or channel 1 counting
// - channel 1 select 000 suppresses captures sourced from its counting
module mct_cfg
   import mct_pkg::*;
(
   input  wire  logic                      ref_clk,
   input  wire  logic                      sys_rst,
   input  wire  logic                      hsel,
   input  wire  logic [31:0]               haddr,
   input  wire  logic [1:0]                htrans,
   input  wire  logic                      hwrite,
   input  wire  logic [2:0]                hsize,
   input  wire  logic [31:0]               hwdata,
   input  wire  logic                      hready,
   output logic       [31:0]               hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   input  wire  logic                      ext_count_pin_a,
   input  wire  logic                      ext_count_pin_b,
   input  wire  logic                      ext_count_pin_c,
   input  wire  logic                      ext_count_pin_d,
   input  wire  logic                      channel2_wrap,
   input  wire  logic                      channel5_wrap,
   input  wire  logic [NUM_CH-1:0]         counter_cleared,
   input  wire  logic                      ch0_capture_compare_pin_b,
   input  wire  logic                      ch0_capture_compare_pin_d,
   output logic       [NUM_CH-1:0]         count_tick,
   output logic       [NUM_CH-1:0]         counter_run_bit,
   output logic       [NUM_CH-1:0]         pwm1_mode,
   output logic       [NUM_CH-1:0]         pwm2_mode,
   output logic       [NUM_CH-1:0]         phase_count_mode,
   output logic       [NUM_CH-1:0]         buffer_pair_a_en,
   output logic       [NUM_CH-1:0]         buffer_pair_b_en,
   output logic       [NUM_CH-1:0][7:0]    compare_action,
   output logic       [NUM_CH-1:0][7:0]    capture_edges,
   output logic       [NUM_CH-1:0][3:0]    compare_pin_level,
   output logic       [1:0]                ch0_pin_capture,
   output logic       [1:0]                ch0_cascade_capture
);

   // decode one 4-bit function code into a compare action
   function automatic logic [1:0] oc_action(input logic [3:0] code);
      oc_action = code[3] ? OC_NONE : code[1:0];
   endfunction : oc_action

   // decode one 4-bit function code into pin capture edges
   function automatic logic [1:0] cap_edge(input logic [3:0] code);
      if (!code[3] || code[2])
         cap_edge = CAP_NONE;
      else if (code[1])
         cap_edge = CAP_BOTH;
      else
         cap_edge = code[0] ? CAP_FALL : CAP_RISE;
   endfunction : cap_edge

   function automatic logic has_cd(input int ch);
      has_cd = (ch == 0) || (ch == 3);
   endfunction : has_cd

   // register state
   logic [2:0]        clk_sel_q [NUM_CH];
   logic [5:0]        mode_q    [NUM_CH];
   logic [7:0]        io_ab_q   [NUM_CH];
   logic [7:0]        io_cd_q   [NUM_CH];
   logic [NUM_CH-1:0] run_q;
   logic [3:0]        level_q   [NUM_CH];

   // ahb data phase state
   logic              wr_pend_q;
   logic              rd_pend_q;
   logic [7:0]        addr_q;
   logic              addr_phase;

   // prescaler and synchronisers
   logic [PRE_W-1:0]  pre_q;
   logic [6:0]        div_tick;
   logic [3:0]        pin_s1_q;
   logic [3:0]        pin_s2_q;
   logic [3:0]        pin_s3_q;
   logic [3:0]        pin_edge;
   logic [1:0]        wrap_q;
   logic [1:0]        wrap_d1_q;
   logic [1:0]        wrap_edge;
   logic [1:0]        cap_s1_q;
   logic [1:0]        cap_s2_q;
   logic [1:0]        cap_s3_q;
   logic [NUM_CH-1:0] src_tick;

   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign addr_phase = hsel && htrans[1] && hready;

   // address phase capture
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_q <= addr_phase && hwrite;
         rd_pend_q <= addr_phase && !hwrite;
         addr_q    <= haddr[7:0];
      end
   end

   // register writes in the data phase
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            clk_sel_q[c] <= CLK_SEL_RST;
            mode_q[c]    <= MODE_RST[5:0];
            io_ab_q[c]   <= IO_RST;
            io_cd_q[c]   <= IO_RST;
         end
         run_q <= '0;
      end
      else if (wr_pend_q)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (addr_q[7:4] == 4'(c))
            begin
               unique case (addr_q[3:0])
                  OFS_CLK_CTRL: clk_sel_q[c] <= hwdata[2:0];
                  OFS_MODE:
                  begin
                     mode_q[c][3:0] <= hwdata[3:0];
                     if (has_cd(c))
                        mode_q[c][5:4] <= hwdata[5:4];
                  end
                  OFS_IO_AB:    io_ab_q[c] <= hwdata[7:0];
                  OFS_IO_CD:
                  begin
                     if (has_cd(c))
                        io_cd_q[c] <= hwdata[7:0];
                  end
                  default: ;
               endcase
            end
         end
         if (addr_q == OFS_RUN)
            run_q <= hwdata[NUM_CH-1:0];
      end
   end

   // read mux in the data phase; unmapped words read zero
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (rd_pend_q)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (addr_q[7:4] == 4'(c))
            begin
               unique case (addr_q[3:0])
                  OFS_CLK_CTRL: hrdata[2:0] = clk_sel_q[c];
                  OFS_MODE:     hrdata[7:0] = {MODE_FIXED_ONES, has_cd(c) ? mode_q[c][5:4] : 2'h0,
                                               mode_q[c][3:0]};
                  OFS_IO_AB:    hrdata[7:0] = io_ab_q[c];
                  OFS_IO_CD:    hrdata[7:0] = has_cd(c) ? io_cd_q[c] : 8'h00;
                  default: ;
               endcase
            end
         end
         if (addr_q == OFS_RUN)
            hrdata[NUM_CH-1:0] = run_q;
      end
   end

   // free-running prescaler
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pre_q <= '0;
      else
         pre_q <= pre_q + 12'h001;
   end

   assign div_tick[DIV1]    = 1'b1;
   assign div_tick[DIV4]    = &pre_q[1:0];
   assign div_tick[DIV16]   = &pre_q[3:0];
   assign div_tick[DIV64]   = &pre_q[5:0];
   assign div_tick[DIV256]  = &pre_q[7:0];
   assign div_tick[DIV1024] = &pre_q[9:0];
   assign div_tick[DIV4096] = &pre_q[11:0];

   // external pins: synchronise, then rising edge; wrap events: register once, then rising edge
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_s1_q  <= '0;
         pin_s2_q  <= '0;
         pin_s3_q  <= '0;
         wrap_q    <= '0;
         wrap_d1_q <= '0;
         cap_s1_q  <= '0;
         cap_s2_q  <= '0;
         cap_s3_q  <= '0;
      end
      else
      begin
         pin_s1_q  <= {ext_count_pin_d, ext_count_pin_c, ext_count_pin_b, ext_count_pin_a};
         pin_s2_q  <= pin_s1_q;
         pin_s3_q  <= pin_s2_q;
         wrap_q    <= {channel5_wrap, channel2_wrap};
         wrap_d1_q <= wrap_q;
         cap_s1_q  <= {ch0_capture_compare_pin_d, ch0_capture_compare_pin_b};
         cap_s2_q  <= cap_s1_q;
         cap_s3_q  <= cap_s2_q;
      end
   end

   assign pin_edge  = pin_s2_q & ~pin_s3_q;
   assign wrap_edge = wrap_q & ~wrap_d1_q;

   // per-channel clock source, mode decode and i/o function decode
   generate
      for (genvar c = 0; c < NUM_CH; c++)
      begin : g_ch
         logic       phase;
         logic       buf_a;
         logic       buf_b;
         logic [3:0] code [4];
         logic [3:0] init_lvl;

         always_comb
         begin
            src_tick[c] = 1'b0;
            if (!clk_sel_q[c][2])
               src_tick[c] = div_tick[clk_sel_q[c][1:0]];
            else
            begin
               unique case (c)
                  0: src_tick[c] = pin_edge[clk_sel_q[c][1:0]];
                  1:
                  begin
                     unique case (clk_sel_q[c][1:0])
                        2'h0: src_tick[c] = pin_edge[0];
                        2'h1: src_tick[c] = pin_edge[1];
                        2'h2: src_tick[c] = div_tick[DIV256];
                        2'h3: src_tick[c] = wrap_edge[0];
                     endcase
                  end
                  2:
                  begin
                     unique case (clk_sel_q[c][1:0])
                        2'h0: src_tick[c] = pin_edge[0];
                        2'h1: src_tick[c] = pin_edge[1];
                        2'h2: src_tick[c] = pin_edge[2];
                        2'h3: src_tick[c] = div_tick[DIV1024];
                     endcase
                  end
                  3:
                  begin
                     unique case (clk_sel_q[c][1:0])
                        2'h0: src_tick[c] = pin_edge[0];
                        2'h1: src_tick[c] = div_tick[DIV1024];
                        2'h2: src_tick[c] = div_tick[DIV256];
                        2'h3: src_tick[c] = div_tick[DIV4096];
                     endcase
                  end
                  4:
                  begin
                     unique case (clk_sel_q[c][1:0])
                        2'h0: src_tick[c] = pin_edge[0];
                        2'h1: src_tick[c] = pin_edge[2];
                        2'h2: src_tick[c] = div_tick[DIV1024];
                        2'h3: src_tick[c] = wrap_edge[1];
                     endcase
                  end
                  default:
                  begin
                     unique case (clk_sel_q[c][1:0])
                        2'h0: src_tick[c] = pin_edge[0];
                        2'h1: src_tick[c] = pin_edge[2];
                        2'h2: src_tick[c] = div_tick[DIV256];
                        2'h3: src_tick[c] = pin_edge[3];
                     endcase
                  end
               endcase
            end
         end

         // phase counting exists only off channels 0 and 3
         assign phase = !has_cd(c) && (mode_q[c][3:2] == MD_PHASE_TOP);
         assign buf_a = has_cd(c) && mode_q[c][MODE_BUF_A_POS];
         assign buf_b = has_cd(c) && mode_q[c][MODE_BUF_B_POS];

         assign count_tick[c]       = run_q[c] && !phase && src_tick[c];
         assign phase_count_mode[c] = phase;
         assign pwm1_mode[c]        = mode_q[c][3:0] == MD_PWM1;
         assign pwm2_mode[c]        = mode_q[c][3:0] == MD_PWM2;
         assign buffer_pair_a_en[c] = buf_a;
         assign buffer_pair_b_en[c] = buf_b;

         // slots a, b, c, d; buffered c or d is forced inert
         assign code[0] = io_ab_q[c][3:0];
         assign code[1] = io_ab_q[c][7:4];
         assign code[2] = (buf_a || !has_cd(c)) ? 4'h0 : io_cd_q[c][3:0];
         assign code[3] = (buf_b || !has_cd(c)) ? 4'h0 : io_cd_q[c][7:4];

         for (genvar s = 0; s < 4; s++)
         begin : g_slot
            assign compare_action[c][2*s+1:2*s] = oc_action(code[s]);
            assign capture_edges[c][2*s+1:2*s]  = cap_edge(code[s]);
            assign init_lvl[s]                  = code[s][2];
         end

         // initial level while stopped; pwm2 loads it at each clear
         always_ff @(posedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               level_q[c] <= 4'h0;
            else if (!run_q[c])
               level_q[c] <= init_lvl;
            else if (pwm2_mode[c] && counter_cleared[c])
               level_q[c] <= init_lvl;
         end
         assign compare_pin_level[c] = level_q[c];
      end
   endgenerate

   assign counter_run_bit = run_q;

   // channel 0 b and d captures: pin edges, or channel 1 counting
   generate
      for (genvar k = 0; k < 2; k++)
      begin : g_cap
         logic [1:0] edg;
         logic       rise;
         logic       fall;
         logic [3:0] fcode;

         assign fcode = (k == 0) ? g_ch[0].code[1] : g_ch[0].code[3];
         assign edg   = cap_edge(fcode);
         assign rise  = cap_s2_q[k] && !cap_s3_q[k];
         assign fall  = !cap_s2_q[k] && cap_s3_q[k];
         assign ch0_pin_capture[k] = (edg[0] && rise) || (edg[1] && fall);
         assign ch0_cascade_capture[k] = (fcode[3:2] == 2'h3) && count_tick[1]
                                         && (clk_sel_q[1] != CLK_SEL_RST);
      end
   endgenerate

endmodule : mct_cfg

`default_nettype wire

// *** tb/mct_cfg_assertions.sv ***
/*
 checker for the timer configuration block, watching only its ports.
 assumes one clock domain, ref_clk, and the async reset sys_rst.
*/
`timescale 1ns/100ps
`default_nettype none
module mct_cfg_checker
   import mct_pkg::*;
(
   input wire logic                          ref_clk,
   input wire logic                          sys_rst,
   input wire logic                          hsel,
   input wire logic [1:0]                    htrans,
   input wire logic                          hwrite,
   input wire logic                          hready,
   input wire logic [31:0]                   hrdata,
   input wire logic [mct_pkg::NUM_CH-1:0]    count_tick,
   input wire logic [mct_pkg::NUM_CH-1:0]    counter_run_bit,
   input wire logic [mct_pkg::NUM_CH-1:0]    phase_count_mode,
   input wire logic [mct_pkg::NUM_CH-1:0]    counter_cleared,
   input wire logic [mct_pkg::NUM_CH-1:0]    buffer_pair_a_en,
   input wire logic [mct_pkg::NUM_CH-1:0]    buffer_pair_b_en,
   input wire logic [mct_pkg::NUM_CH-1:0][7:0] compare_action,
   input wire logic [mct_pkg::NUM_CH-1:0][7:0] capture_edges,
   input wire logic [mct_pkg::NUM_CH-1:0][3:0] compare_pin_level,
   input wire logic [1:0]                    ch0_pin_capture,
   input wire logic [1:0]                    ch0_cascade_capture
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_tick_needs_run: assert property ((count_tick & ~counter_run_bit) == '0)
      else $error("count tick while counter stopped");
   a_phase_no_tick: assert property ((count_tick & phase_count_mode & 6'h36) == '0)
      else $error("count tick in phase counting mode");
   a_buf_reserved: assert property (((buffer_pair_a_en | buffer_pair_b_en) & 6'h36) == '0)
      else $error("buffer enable on channel without c and d");
   a_buf_d_quiet: assert property (buffer_pair_b_en[0] && $past(buffer_pair_b_en[0]) |->
      {compare_action[0][7:6], capture_edges[0][7:6]} == 4'h0) else $error("buffered d still active");
   a_buf_c_quiet: assert property (buffer_pair_a_en[3] && $past(buffer_pair_a_en[3]) |->
      {compare_action[3][5:4], capture_edges[3][5:4]} == 4'h0) else $error("buffered c still active");
   a_level_held: assert property (counter_run_bit[1] && $past(counter_run_bit[1]) &&
      !$past(counter_cleared[1]) |-> $stable(compare_pin_level[1])) else $error("level moved while running");
   a_cascade_src: assert property (ch0_cascade_capture[0] |-> count_tick[1] || $past(count_tick[1]))
      else $error("cascade capture without channel 1 count");
   a_read_idle: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == '0)
      else $error("read data outside read data phase");

   c_tick: cover property (count_tick[0]);
   c_pin_cap: cover property (ch0_pin_capture[0]);
   c_casc_cap: cover property (ch0_cascade_capture[0]);
   c_buffer: cover property (buffer_pair_b_en[0]);
endmodule : mct_cfg_checker

bind mct_cfg mct_cfg_checker u_mct_cfg_checker (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .count_tick(count_tick),
   .counter_run_bit(counter_run_bit), .phase_count_mode(phase_count_mode), .counter_cleared(counter_cleared),
   .buffer_pair_a_en(buffer_pair_a_en), .buffer_pair_b_en(buffer_pair_b_en), .compare_action(compare_action),
   .capture_edges(capture_edges), .compare_pin_level(compare_pin_level), .ch0_pin_capture(ch0_pin_capture),
   .ch0_cascade_capture(ch0_cascade_capture));
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 self-checking bench for the timer configuration block.
 assumes an always-ready ahb-lite slave and the checker bound elsewhere.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import mct_pkg::*;
   // expected ticks in 4096 cycles for select codes 4..7
   localparam int HI [NUM_CH][4] = '{'{683, 410, 293, 228}, '{683, 410, 16, 186}, '{683, 410, 293, 4},
                                    '{683, 4, 16, 1}, '{683, 293, 4, 157}, '{683, 293, 16, 228}};
   logic                   ref_clk = 1'h0;
   logic                   sys_rst = 1'h1;
   logic                   hsel = 1'h0, hwrite = 1'h0;
   logic [1:0]             htrans = 2'h0;
   logic [31:0]            haddr = '0, hwdata = '0;
   logic                   hready, hreadyout, hresp;
   logic [31:0]            hrdata, rd;
   logic                   pin_a = 1'h0, pin_b = 1'h0, pin_c = 1'h0, pin_d = 1'h0, wrap2 = 1'h0, wrap5 = 1'h0;
   logic                   cap_b = 1'h0, meas = 1'h0;
   logic [NUM_CH-1:0]      clr = '0, tick, run, pwm1, pwm2, phase, buf_a, buf_b;
   logic [NUM_CH-1:0][7:0] act, edges;
   logic [NUM_CH-1:0][3:0] lvl;
   logic [1:0]             pcap, ccap;
   int                     num_errors = 0, comparisons = 0, cyc = 0;
   int                     n [8];

   always #50 ref_clk = ~ref_clk;
   assign hready = hreadyout;

   // free-running pin and wrap stimulus, distinct periods
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      pin_a <= (cyc % 6) < 3;
      pin_b <= (cyc % 10) < 5;
      pin_c <= (cyc % 14) < 7;
      pin_d <= (cyc % 18) < 9;
      wrap2 <= (cyc % 22) < 11;
      wrap5 <= (cyc % 26) < 13;
   end

   // pulse counters sampled mid-cycle
   always @(negedge ref_clk)
      if (meas)
      begin
         for (int c = 0; c < NUM_CH; c++)
            n[c] += int'(tick[c] === 1'h1);
         n[6] += int'(pcap[0] === 1'h1) + int'(pcap[1] === 1'h1);
         n[7] += int'(ccap[0] === 1'h1) + int'(ccap[1] === 1'h1);
      end

   mct_cfg u_mct_cfg (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ext_count_pin_a(pin_a), .ext_count_pin_b(pin_b), .ext_count_pin_c(pin_c),
      .ext_count_pin_d(pin_d), .channel2_wrap(wrap2), .channel5_wrap(wrap5), .counter_cleared(clr),
      .ch0_capture_compare_pin_b(cap_b), .ch0_capture_compare_pin_d(cap_b), .count_tick(tick),
      .counter_run_bit(run), .pwm1_mode(pwm1), .pwm2_mode(pwm2), .phase_count_mode(phase),
      .buffer_pair_a_en(buf_a), .buffer_pair_b_en(buf_b), .compare_action(act), .capture_edges(edges),
      .compare_pin_level(lvl), .ch0_pin_capture(pcap), .ch0_cascade_capture(ccap));

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   // count compare with one pulse of slack for sync and prescaler phase
   task automatic near(input string what, input int exp, input int got);
      check(what, (got >= exp - 1 && got <= exp + 1) ? 32'(exp) : 32'(got), 32'(exp));
   endtask : near

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge ref_clk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'h1);
      rd = hrdata;
   endtask : bus

   task automatic wreg(input logic [31:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
      repeat (2) @(posedge ref_clk);
   endtask : wreg

   task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      check(what, rd, exp);
   endtask : rchk

   function automatic logic [31:0] ra(input int c, input logic [3:0] ofs);
      return 32'(c) * 32'(CH_STRIDE) + 32'(ofs);
   endfunction : ra

   task automatic measure(input int w);
      n = '{default: 0};
      meas <= 1'h1;
      repeat (w) @(posedge ref_clk);
      meas <= 1'h0;
   endtask : measure

   task automatic t_reset;
      for (int c = 0; c < NUM_CH; c++)
      begin
         rchk("clock select", ra(c, OFS_CLK_CTRL), 32'(CLK_SEL_RST));
         rchk("mode", ra(c, OFS_MODE), 32'(MODE_RST));
         rchk("io ab", ra(c, OFS_IO_AB), 32'(IO_RST));
         rchk("io cd", ra(c, OFS_IO_CD), 32'(IO_RST));
      end
      rchk("unmapped", 32'h70, 32'h0);
      $display("test reset values done");
   endtask : t_reset

   task automatic t_mode;
      for (int c = 0; c < NUM_CH; c++)
      begin
         wreg(ra(c, OFS_MODE), 32'h33);
         rchk("mode bits", ra(c, OFS_MODE), (c == 0 || c == 3) ? 32'hF3 : 32'hC3);
      end
      check("pwm2 and buffers", {hreadyout, hresp, pwm2, buf_b, buf_a}, {2'h2, 6'h3F, 6'h09, 6'h09});
      for (int m = 0; m < 8; m++)
      begin
         wreg(ra(1, OFS_MODE), 32'(m));
         check("mode decode", {pwm1[1], pwm2[1], phase[1]}, {m == 2, m == 3, m > 3});
      end
      for (int c = 0; c < NUM_CH; c++)
         wreg(ra(c, OFS_MODE), 32'h0);
      $display("test mode register done");
   endtask : t_mode

   task automatic t_clock;
      wreg(32'(OFS_RUN), 32'h3F);
      for (int s = 0; s < 8; s++)
      begin
         for (int c = 0; c < NUM_CH; c++)
            wreg(ra(c, OFS_CLK_CTRL), 32'(s));
         measure(4096);
         for (int c = 0; c < NUM_CH; c++)
            near("tick count", (s < 4) ? (4096 >> (2 * s)) : HI[c][s - 4], n[c]);
      end
      for (int c = 1; c < NUM_CH; c++)
         wreg(ra(c, OFS_MODE), (c == 3) ? 32'h0 : 32'h4);
      measure(256);
      check("phase mode ticks", 32'(n[1] + n[2] + n[4] + n[5]), 32'h0);
      for (int c = 1; c < NUM_CH; c++)
         wreg(ra(c, OFS_MODE), 32'h0);
      wreg(32'(OFS_RUN), 32'h0);
      $display("test clock sources done");
   endtask : t_clock

   task automatic t_io;
      for (int k = 0; k < 8; k++)
      begin
         wreg(ra(1, OFS_IO_AB), 32'({k[3:0], k[3:0]}));
         check("compare decode", {act[1][3:0], edges[1][3:0], lvl[1][1:0]}, {k[1:0], k[1:0], 4'h0, k[2], k[2]});
      end
      for (int k = 8; k < 12; k++)
      begin
         wreg(ra(0, OFS_IO_AB), 32'(k << 4));
         wreg(ra(0, OFS_IO_CD), 32'(k << 4));
         check("capture edges", {edges[0][7:6], edges[0][3:2], act[0][7:6], act[0][3:2]},
            {{2{(k > 9) ? CAP_BOTH : (k == 9) ? CAP_FALL : CAP_RISE}}, 4'h0});
      end
      wreg(ra(1, OFS_IO_AB), 32'h44);
      wreg(32'(OFS_RUN), 32'h02);
      wreg(ra(1, OFS_IO_AB), 32'h11);
      check("held level", {run, lvl[1][1:0]}, {6'h02, 2'h3});
      wreg(ra(1, OFS_MODE), 32'(MD_PWM2));
      clr <= 6'h02;
      @(posedge ref_clk);
      clr <= 6'h00;
      repeat (2) @(posedge ref_clk);
      check("clear level", lvl[1][1:0], 2'h0);
      wreg(ra(1, OFS_MODE), 32'h0);
      wreg(32'(OFS_RUN), 32'h0);
      $display("test io control done");
   endtask : t_io

   task automatic t_buffer;
      for (int c = 0; c < 4; c += 3)
      begin
         wreg(ra(c, OFS_MODE), 32'h30);
         wreg(ra(c, OFS_IO_CD), 32'h55);
         check("buffered slots", {act[c][7:4], lvl[c][3:2]}, 6'h0);
         rchk("io cd kept", ra(c, OFS_IO_CD), 32'h55);
         wreg(ra(c, OFS_MODE), 32'h0);
         @(posedge ref_clk);
         check("unbuffered slots", {act[c][7:4], lvl[c][3:2]}, 6'h17);
      end
      wreg(ra(1, OFS_IO_CD), 32'h55);
      rchk("io cd absent", ra(1, OFS_IO_CD), 32'h0);
      $display("test buffer pairing done");
   endtask : t_buffer

   task automatic t_capture;
      for (int k = 8; k < 11; k++)
      begin
         wreg(ra(0, OFS_IO_AB), 32'(k << 4));
         wreg(ra(0, OFS_IO_CD), 32'(k << 4));
         cap_b <= 1'h1;
         measure(12);
         check("rise capture", 32'(n[6]), 32'(2 * (k != 9)));
         cap_b <= 1'h0;
         measure(12);
         check("fall capture", 32'(n[6]), 32'(2 * (k != 8)));
      end
      wreg(ra(0, OFS_IO_AB), 32'hC0);
      wreg(ra(0, OFS_IO_CD), 32'hC0);
      wreg(ra(1, OFS_CLK_CTRL), 32'h1);
      wreg(32'(OFS_RUN), 32'h02);
      measure(64);
      near("cascade capture", 32, n[7]);
      wreg(ra(1, OFS_CLK_CTRL), 32'h0);
      measure(64);
      check("suppressed capture", 32'(n[7]), 32'h0);
      $display("test capture sources done");
   endtask : t_capture

   initial
   begin
      repeat (60000) @(posedge ref_clk);
      num_errors++;
      $display("ERROR watchdog expected finish seen hang");
      give_verdict();
   end

   initial
   begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'h0;
      @(posedge ref_clk);
      t_reset();
      t_mode();
      t_clock();
      t_io();
      t_buffer();
      t_capture();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
